// file: hdl/dcc_pkg.sv
// Purpose: Shared constants for the DMA channel control block
// Assumes: Registers sit on a 4-bit word-aligned byte address
// Notes:   Field positions, reset values and offsets only
// =====================================================================
// Package
package dcc_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] EVT_OFS  = 4'h4;
  localparam logic [3:0] INT_OFS  = 4'h8;

  // Control register fields
  localparam int BUSY_BIT  = 15;
  localparam int CDIR_BIT  = 8;
  localparam int ON_BIT    = 7;
  localparam int EWO_BIT   = 6;
  localparam int CHAIN_BIT = 5;
  localparam int AUTO_BIT  = 4;
  localparam int SEEN_BIT  = 2;
  localparam int PRIO_LSB  = 0;

  // Event control register fields
  localparam int ANUM_LSB  = 16;
  localparam int SNUM_LSB  = 8;
  localparam int FORCE_BIT = 7;
  localparam int SABRT_BIT = 6;
  localparam int PAT_BIT   = 5;
  localparam int SIEN_BIT  = 4;
  localparam int AIEN_BIT  = 3;

  // Interrupt control register fields
  localparam int IE_LSB    = 16;
  localparam int FLAG_LSB  = 0;

  // Flag vector positions
  localparam int F_SRC_DONE = 7;
  localparam int F_SRC_HALF = 6;
  localparam int F_DST_DONE = 5;
  localparam int F_DST_HALF = 4;
  localparam int F_BLOCK    = 3;
  localparam int F_CELL     = 2;
  localparam int F_ABORT    = 1;
  localparam int F_ADDR_ERR = 0;

  // Reset values
  localparam logic [7:0]  IRQ_NUM_RST = 8'hff;
  localparam logic [31:0] RD_IDLE     = 32'h0000_0000;

endpackage : dcc_pkg

// file: hdl/dcc_match_if.sv
// Purpose: Carries irq numbers to the matcher and match results back
// Assumes: All signals on mclk
// Notes:   ctl side drives config, mat side returns hits
// =====================================================================
// Interface
interface dcc_match_if;
  logic       irq_valid;
  logic [7:0] irq_num;
  logic [7:0] start_num;
  logic [7:0] abort_num;
  logic       start_en;
  logic       abort_en;
  logic       start_hit;
  logic       abort_hit;

  modport ctl (output irq_valid, irq_num, start_num, abort_num,
               output start_en, abort_en, input start_hit, abort_hit);
  modport mat (input irq_valid, irq_num, start_num, abort_num,
               input start_en, abort_en, output start_hit, abort_hit);
endinterface : dcc_match_if

// file: hdl/dcc_irq_match.sv
// Purpose: Compares an arriving interrupt number to start/abort picks
// Assumes: irq_valid is a one-cycle strobe on mclk
// Notes:   Purely combinational
// =====================================================================
// Matcher
module dcc_irq_match (
  dcc_match_if.mat m
);

  // Number compare gated by strobe and enable
  function automatic logic hit(input logic       v,
                               input logic       en,
                               input logic [7:0] num,
                               input logic [7:0] sel);
    hit = v & en & (num == sel);
  endfunction : hit

  // Start and abort decode
  assign m.start_hit = hit(m.irq_valid, m.start_en, m.irq_num,
                           m.start_num);
  assign m.abort_hit = hit(m.irq_valid, m.abort_en, m.irq_num,
                           m.abort_num);

endmodule : dcc_irq_match

// file: hdl/dcc_flags.sv
// Purpose: Eight sticky channel flags and the channel request
// Assumes: Set pulses and write come from mclk logic
// Notes:   A set in the same cycle as a write of zero wins
// =====================================================================
// Flags
module dcc_flags (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] set,
  input  wire logic [7:0] ie,
  output logic      [7:0] flags_q,
  output logic            irq_q
);

  // One sticky bit per flag
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_flag
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          flags_q[i] <= 1'b0;
        end else if (set[i]) begin
          flags_q[i] <= 1'b1;
        end else if (wr_en) begin
          flags_q[i] <= wdata[i];
        end
      end
    end
  endgenerate

  // Request from any enabled pending flag
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & ie);
    end
  end

  chk_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
    (set != 8'h00) |=> ((flags_q & $past(set)) == $past(set)))
    else $error("flag set lost");

  chk_irq_follow: assert property (@(posedge mclk) disable iff (reset)
    (|(flags_q & ie)) |=> irq_q)
    else $error("request missing for enabled flag");

  chk_irq_drop: assert property (@(posedge mclk) disable iff (reset)
    !(|(flags_q & ie)) |=> !irq_q)
    else $error("request without enabled flag");

endmodule : dcc_flags

// file: hdl/dcc_channel.sv
// Purpose: Control, trigger events and flags of one DMA channel
// Assumes: Datapath reports progress with one-cycle pulses on mclk
// Notes:   Registers reached over a plain strobe port
// =====================================================================
// Summary of operation
// - Busy bit shows channel active or enabled
// - Chain enable lets neighbour completion enable channel
// - Chain direction picks higher or lower neighbour
// - Disable suspends only after current transaction ends
// - Events while disabled kept only if allowed
// - Auto enable keeps channel on after block
// - Event seen bit set on trigger event
// - Two-bit priority field, three is highest
// - Abort irq number aborts and flags abort
// - Start irq number launches a transfer
// - Force bit starts transfer, reads zero
// - Soft abort bit aborts transfer, reads zero
// - Pattern match aborts and clears enable
// - Start irq enable gates start by irq
// - Abort irq enable gates abort by irq
// - Eight enables, one per channel flag
// - Source done flag when pointer equals size
// - Source half flag at half the size
// - Block flag on block end or pattern
// - Abort flag on matching abort irq
// - Cell flag when cell transferred
// - Address error flag on bad address
module dcc_channel (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        irq_valid,
  input  wire logic [7:0]  irq_num,
  input  wire logic        chain_hi_done,
  input  wire logic        chain_lo_done,
  input  wire logic        txn_idle,
  input  wire logic        src_step,
  input  wire logic [15:0] src_pointer,
  input  wire logic [15:0] src_size,
  input  wire logic        dst_done_evt,
  input  wire logic        dst_half_evt,
  input  wire logic        cell_done_evt,
  input  wire logic        block_done_evt,
  input  wire logic        addr_err_evt,
  input  wire logic        pattern_match_evt,
  output logic             start_req,
  output logic             abort_req,
  output logic             chan_enabled,
  output logic             chan_busy,
  output logic      [1:0]  chan_prio,
  output logic             chan_irq
);

  // =====================================================================
  // Declarations
  typedef enum logic [1:0] {DCC_IDLE, DCC_RUN, DCC_SUSP} dcc_state_t;

  dcc_state_t  state_q;
  dcc_state_t  state_d;
  logic        chan_on_q;
  logic        chan_on_d;
  logic        events_while_off_q;
  logic        chaining_allow_q;
  logic        auto_reenable_q;
  logic        chain_direction_q;
  logic [1:0]  chan_priority_q;
  logic        event_seen_q;
  logic        busy_q;
  logic [7:0]  abort_irq_number_q;
  logic [7:0]  start_irq_number_q;
  logic        pattern_abort_enable_q;
  logic        start_irq_enable_q;
  logic        abort_irq_enable_q;
  logic [7:0]  ie_q;
  logic [7:0]  flags;
  logic [7:0]  flag_set;
  logic        start_pend_q;
  logic        start_req_q;
  logic        abort_req_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;
  logic        wr_ctrl;
  logic        wr_evt;
  logic        wr_int;
  logic        events_ok;
  logic        force_hit;
  logic        sabort_hit;
  logic        start_evt;
  logic        pat_abort;
  logic        irq_abort;
  logic        abort_evt;
  logic        chain_evt;
  logic        blk_end;
  logic        launch;

  // Write decode for one register
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [3:0] addr,
                                   input logic [3:0] ofs);
    reg_hit = strobe & (addr == ofs);
  endfunction : reg_hit

  assign wr_ctrl = reg_hit(reg_wr, reg_addr, dcc_pkg::CTRL_OFS);
  assign wr_evt  = reg_hit(reg_wr, reg_addr, dcc_pkg::EVT_OFS);
  assign wr_int  = reg_hit(reg_wr, reg_addr, dcc_pkg::INT_OFS);

  // =====================================================================
  // Interrupt number matching
  dcc_match_if mif ();

  assign mif.irq_valid = irq_valid;
  assign mif.irq_num   = irq_num;
  assign mif.start_num = start_irq_number_q;
  assign mif.abort_num = abort_irq_number_q;
  assign mif.start_en  = start_irq_enable_q;
  assign mif.abort_en  = abort_irq_enable_q;

  dcc_irq_match u_match (
    .m (mif.mat)
  );

  // =====================================================================
  // Trigger events
  assign events_ok  = chan_on_q | events_while_off_q;
  assign force_hit  = wr_evt & reg_wdata[dcc_pkg::FORCE_BIT];
  assign sabort_hit = wr_evt & reg_wdata[dcc_pkg::SABRT_BIT];
  assign start_evt  = events_ok & (force_hit | mif.start_hit);
  assign irq_abort  = events_ok & mif.abort_hit;
  assign pat_abort  = pattern_abort_enable_q & pattern_match_evt;
  assign abort_evt  = irq_abort | (events_ok & sabort_hit) | pat_abort;
  assign blk_end    = block_done_evt | pat_abort;
  assign chain_evt  = chaining_allow_q &
                      (chain_direction_q ? chain_hi_done
                                         : chain_lo_done);

  // =====================================================================
  // Control register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      events_while_off_q <= 1'b0;
      chaining_allow_q   <= 1'b0;
      auto_reenable_q    <= 1'b0;
      chain_direction_q  <= 1'b0;
      chan_priority_q    <= 2'b00;
    end else if (wr_ctrl) begin
      events_while_off_q <= reg_wdata[dcc_pkg::EWO_BIT];
      chaining_allow_q   <= reg_wdata[dcc_pkg::CHAIN_BIT];
      auto_reenable_q    <= reg_wdata[dcc_pkg::AUTO_BIT];
      chain_direction_q  <= reg_wdata[dcc_pkg::CDIR_BIT];
      chan_priority_q    <= reg_wdata[dcc_pkg::PRIO_LSB +: 2];
    end
  end

  // Channel enable: write, then hardware clear, then chain set
  always_comb begin
    chan_on_d = chan_on_q;
    if (wr_ctrl) begin
      chan_on_d = reg_wdata[dcc_pkg::ON_BIT];
    end
    if ((blk_end && !auto_reenable_q) || pat_abort) begin
      chan_on_d = 1'b0;
    end
    if (chain_evt) begin
      chan_on_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      chan_on_q <= 1'b0;
    end else begin
      chan_on_q <= chan_on_d;
    end
  end

  // =====================================================================
  // Event control and interrupt enable registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      abort_irq_number_q     <= dcc_pkg::IRQ_NUM_RST;
      start_irq_number_q     <= dcc_pkg::IRQ_NUM_RST;
      pattern_abort_enable_q <= 1'b0;
      start_irq_enable_q     <= 1'b0;
      abort_irq_enable_q     <= 1'b0;
    end else if (wr_evt) begin
      abort_irq_number_q     <= reg_wdata[dcc_pkg::ANUM_LSB +: 8];
      start_irq_number_q     <= reg_wdata[dcc_pkg::SNUM_LSB +: 8];
      pattern_abort_enable_q <= reg_wdata[dcc_pkg::PAT_BIT];
      start_irq_enable_q     <= reg_wdata[dcc_pkg::SIEN_BIT];
      abort_irq_enable_q     <= reg_wdata[dcc_pkg::AIEN_BIT];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ie_q <= 8'h00;
    end else if (wr_int) begin
      ie_q <= reg_wdata[dcc_pkg::IE_LSB +: 8];
    end
  end

  // =====================================================================
  // Pending start and event seen, set wins over clear
  assign launch = (state_q == DCC_IDLE) & chan_on_q & start_pend_q &
                  ~abort_evt;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      start_pend_q <= 1'b0;
    end else begin
      start_pend_q <= start_evt |
                      (start_pend_q & ~launch & ~abort_evt);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      event_seen_q <= 1'b0;
    end else begin
      event_seen_q <= start_evt |
                      (event_seen_q & ~blk_end & ~abort_evt);
    end
  end

  // =====================================================================
  // Transfer state
  always_comb begin
    state_d = state_q;
    case (state_q)
      DCC_IDLE: begin
        if (launch) begin
          state_d = DCC_RUN;
        end
      end
      DCC_RUN: begin
        if (abort_evt || blk_end || cell_done_evt) begin
          state_d = DCC_IDLE;
        end else if (!chan_on_q && txn_idle) begin
          state_d = DCC_SUSP;
        end
      end
      DCC_SUSP: begin
        if (abort_evt) begin
          state_d = DCC_IDLE;
        end else if (chan_on_q) begin
          state_d = DCC_RUN;
        end
      end
      default: begin
        state_d = DCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= DCC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Busy while enabled or finishing a transaction
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= chan_on_d | (state_d == DCC_RUN);
    end
  end

  // Start and abort pulses to the datapath
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      start_req_q <= 1'b0;
      abort_req_q <= 1'b0;
    end else begin
      start_req_q <= launch;
      abort_req_q <= abort_evt & (state_q != DCC_IDLE);
    end
  end

  // =====================================================================
  // Flags and channel request
  always_comb begin
    flag_set                      = 8'h00;
    flag_set[dcc_pkg::F_SRC_DONE] = src_step &
                                    (src_pointer == src_size);
    flag_set[dcc_pkg::F_SRC_HALF] = src_step &
                                    (src_pointer ==
                                     {1'b0, src_size[15:1]});
    flag_set[dcc_pkg::F_DST_DONE] = dst_done_evt;
    flag_set[dcc_pkg::F_DST_HALF] = dst_half_evt;
    flag_set[dcc_pkg::F_BLOCK]    = blk_end;
    flag_set[dcc_pkg::F_CELL]     = cell_done_evt;
    flag_set[dcc_pkg::F_ABORT]    = irq_abort;
    flag_set[dcc_pkg::F_ADDR_ERR] = addr_err_evt;
  end

  dcc_flags u_flags (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_int),
    .wdata   (reg_wdata[dcc_pkg::FLAG_LSB +: 8]),
    .set     (flag_set),
    .ie      (ie_q),
    .flags_q (flags),
    .irq_q   (chan_irq)
  );

  // =====================================================================
  // Read back, set-only bits read zero
  always_comb begin
    rd_word = dcc_pkg::RD_IDLE;
    case (reg_addr)
      dcc_pkg::CTRL_OFS: begin
        rd_word[dcc_pkg::BUSY_BIT]      = busy_q;
        rd_word[dcc_pkg::CDIR_BIT]      = chain_direction_q;
        rd_word[dcc_pkg::ON_BIT]        = chan_on_q;
        rd_word[dcc_pkg::EWO_BIT]       = events_while_off_q;
        rd_word[dcc_pkg::CHAIN_BIT]     = chaining_allow_q;
        rd_word[dcc_pkg::AUTO_BIT]      = auto_reenable_q;
        rd_word[dcc_pkg::SEEN_BIT]      = event_seen_q;
        rd_word[dcc_pkg::PRIO_LSB +: 2] = chan_priority_q;
      end
      dcc_pkg::EVT_OFS: begin
        rd_word[dcc_pkg::ANUM_LSB +: 8] = abort_irq_number_q;
        rd_word[dcc_pkg::SNUM_LSB +: 8] = start_irq_number_q;
        rd_word[dcc_pkg::PAT_BIT]       = pattern_abort_enable_q;
        rd_word[dcc_pkg::SIEN_BIT]      = start_irq_enable_q;
        rd_word[dcc_pkg::AIEN_BIT]      = abort_irq_enable_q;
      end
      dcc_pkg::INT_OFS: begin
        rd_word[dcc_pkg::IE_LSB +: 8]   = ie_q;
        rd_word[dcc_pkg::FLAG_LSB +: 8] = flags;
      end
      default: begin
        rd_word = dcc_pkg::RD_IDLE;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_q <= dcc_pkg::RD_IDLE;
    end else if (reg_rd) begin
      rdata_q <= rd_word;
    end else begin
      rdata_q <= dcc_pkg::RD_IDLE;
    end
  end

  // Outputs straight from flops
  assign reg_rdata    = rdata_q;
  assign start_req    = start_req_q;
  assign abort_req    = abort_req_q;
  assign chan_enabled = chan_on_q;
  assign chan_busy    = busy_q;
  assign chan_prio    = chan_priority_q;

  // =====================================================================
  // Checks
  chk_busy_level: assert property (@(posedge mclk) disable iff (reset)
    busy_q == (chan_on_q || state_q == DCC_RUN))
    else $error("busy does not track enable or run");

  chk_chain_sel: assert property (@(posedge mclk) disable iff (reset)
    (chaining_allow_q && (chain_direction_q ? chain_hi_done
                                            : chain_lo_done))
    |=> chan_on_q)
    else $error("chained neighbour did not enable channel");

  chk_chain_off: assert property (@(posedge mclk) disable iff (reset)
    (!chaining_allow_q && !chan_on_q && !wr_ctrl) |=> !chan_on_q)
    else $error("channel enabled without chaining or write");

  chk_suspend_wait: assert property (@(posedge mclk) disable iff (reset)
    (state_q == DCC_RUN && !chan_on_d && !txn_idle && !abort_evt &&
     !blk_end && !cell_done_evt) |=> busy_q)
    else $error("busy dropped before transaction end");

  chk_off_ignore: assert property (@(posedge mclk) disable iff (reset)
    (!events_ok && !start_pend_q) |=> !start_pend_q)
    else $error("event kept while disabled");

  chk_auto_clear: assert property (@(posedge mclk) disable iff (reset)
    (block_done_evt && !auto_reenable_q && !chain_evt)
    |=> !chan_on_q)
    else $error("enable kept after block without auto");

  chk_seen_set: assert property (@(posedge mclk) disable iff (reset)
    start_evt |=> event_seen_q)
    else $error("event seen not set");

  chk_force_start: assert property (@(posedge mclk) disable iff (reset)
    (force_hit && chan_on_q && !chain_evt && state_q == DCC_IDLE &&
     !abort_evt && !wr_ctrl && !start_pend_q && !block_done_evt)
    |=> start_pend_q ##1 (start_req_q || $past(abort_evt)))
    else $error("forced start not launched");

  chk_abort_stop: assert property (@(posedge mclk) disable iff (reset)
    (abort_evt && state_q != DCC_IDLE)
    |=> (abort_req_q && state_q == DCC_IDLE))
    else $error("abort did not stop transfer");

  chk_pattern_off: assert property (@(posedge mclk) disable iff (reset)
    (pat_abort && !chain_evt) |=> !chan_on_q)
    else $error("pattern match left channel enabled");

endmodule : dcc_channel

// file: test/dcc_dp_model.sv
// Purpose: Datapath stand-in that runs one cell per launch
// Assumes: start_req and abort_req are one-cycle pulses on mclk
// Notes:   Cell length set by LAT; abort drops the cell silently
// =====================================================================
// Datapath model
module dcc_dp_model #(
  parameter int LAT = 6
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic start_req,
  input  wire logic abort_req,
  output logic      txn_idle,
  output logic      cell_done_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Count down a running cell, end it with a pulse
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt           <= 0;
      cell_done_evt <= 1'b0;
    end else begin
      cell_done_evt <= (cnt == 1) && !abort_req;
      if (start_req) begin
        cnt <= LAT;
      end else if (abort_req) begin
        cnt <= 0;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end

  // Idle whenever no cell is counting
  assign txn_idle = (cnt == 0);
endmodule : dcc_dp_model

// file: test/tb_dcc_channel.sv
// Purpose: Self-checking bench for the channel control block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Event inputs packed in ev; cells come from the model
// =====================================================================
// Bench
module tb_dcc_channel;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CA = dcc_pkg::CTRL_OFS;
  localparam logic [3:0] EA = dcc_pkg::EVT_OFS;
  localparam logic [3:0] IA = dcc_pkg::INT_OFS;
  logic        mclk        = 1'b0;
  logic        reset       = 1'b1;
  logic [3:0]  reg_addr    = 4'h0;
  logic [31:0] reg_wdata   = 32'h0000_0000;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [7:0]  irq_num     = 8'h00;
  logic [8:0]  ev          = 9'h000;
  logic [15:0] src_pointer = 16'h0000;
  logic [15:0] src_size    = 16'h0010;
  logic [31:0] reg_rdata;
  logic [1:0]  chan_prio;
  logic        txn_idle, cell_done_evt, start_req, abort_req;
  logic        chan_enabled, chan_busy, chan_irq;
  int          fail_count  = 0;
  int          check_count = 0;
  int          n_st        = 0;
  int          n_ab        = 0;

  // Clock and pulse counters
  always #5 mclk = ~mclk;
  always @(negedge mclk) begin
    if (start_req === 1'b1) n_st++;
    if (abort_req === 1'b1) n_ab++;
  end

  dcc_channel DUT (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_valid(ev[0]), .irq_num(irq_num),
    .chain_hi_done(ev[1]), .chain_lo_done(ev[2]), .txn_idle(txn_idle),
    .src_step(ev[3]), .src_pointer(src_pointer), .src_size(src_size),
    .dst_done_evt(ev[4]), .dst_half_evt(ev[5]),
    .cell_done_evt(cell_done_evt), .block_done_evt(ev[6]),
    .addr_err_evt(ev[7]), .pattern_match_evt(ev[8]),
    .start_req(start_req), .abort_req(abort_req),
    .chan_enabled(chan_enabled), .chan_busy(chan_busy),
    .chan_prio(chan_prio), .chan_irq(chan_irq)
  );

  dcc_dp_model #(.LAT(6)) dp (
    .mclk(mclk), .reset(reset), .start_req(start_req),
    .abort_req(abort_req), .txn_idle(txn_idle),
    .cell_done_evt(cell_done_evt)
  );

  // ===================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd

  task automatic pulse(input int i, input logic [7:0] n);
    @(posedge mclk);
    ev      <= 9'h001 << i;
    irq_num <= n;
    @(posedge mclk);
    ev      <= 9'h000;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  task automatic conclude();
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    conclude();
  end

  // ===================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rd(CA, 32'h0000_0000);
    rd(EA, 32'h00ff_ff00);
    rd(IA, 32'h0000_0000);
    rd(4'hc, 32'h0000_0000);
    // Enable at top priority, read-only bits written as ones
    wr(CA, 32'h0000_8087);
    rd(CA, 32'h0000_8083);
    chk(chan_prio, 2'b11);
    // Forced start, then the cell completes
    wr(EA, 32'h0000_0080);
    idle(4);
    chk(n_st, 1);
    rd(EA, 32'h0000_0000);
    rd(CA, 32'h0000_8087);
    idle(6);
    rd(IA, 32'h0000_0004);
    // Start and abort by interrupt number
    wr(EA, 32'h0034_1208);
    pulse(0, 8'h12);
    idle(4);
    chk(n_st, 1);
    wr(EA, 32'h0034_1218);
    pulse(0, 8'h13);
    idle(4);
    chk(n_st, 1);
    pulse(0, 8'h12);
    idle(4);
    chk(n_st, 2);
    pulse(0, 8'h34);
    idle(3);
    chk(n_ab, 1);
    rd(IA, 32'h0000_0006);
    rd(CA, 32'h0000_8083);
    // Block end without and with automatic re-enable
    pulse(6, 8'h00);
    idle(3);
    chk(chan_enabled, 1'b0);
    chk(chan_busy, 1'b0);
    wr(CA, 32'h0000_0090);
    pulse(6, 8'h00);
    idle(3);
    chk(chan_enabled, 1'b1);
    // Pattern match turns the channel off
    wr(EA, 32'h0000_0020);
    pulse(8, 8'h00);
    idle(3);
    chk(chan_enabled, 1'b0);
    // Events while off: dropped, then kept
    wr(CA, 32'h0000_0000);
    wr(EA, 32'h0000_0080);
    idle(2);
    rd(CA, 32'h0000_0000);
    wr(CA, 32'h0000_0040);
    wr(EA, 32'h0000_0080);
    idle(2);
    rd(CA, 32'h0000_0044);
    chk(n_st, 2);
    wr(EA, 32'h0000_0040);
    rd(EA, 32'h0000_0000);
    // Chaining picks the neighbour by direction
    wr(CA, 32'h0000_0120);
    pulse(2, 8'h00);
    idle(3);
    chk(chan_enabled, 1'b0);
    pulse(1, 8'h00);
    idle(3);
    chk(chan_enabled, 1'b1);
    wr(CA, 32'h0000_0100);
    pulse(1, 8'h00);
    idle(3);
    chk(chan_enabled, 1'b0);
    wr(CA, 32'h0000_0020);
    pulse(1, 8'h00);
    idle(3);
    chk(chan_enabled, 1'b0);
    pulse(2, 8'h00);
    idle(3);
    chk(chan_enabled, 1'b1);
    // Disable during a running cell
    wr(CA, 32'h0000_0080);
    wr(EA, 32'h0000_0080);
    idle(3);
    wr(CA, 32'h0000_0000);
    idle(1);
    chk(chan_busy, 1'b1);
    idle(8);
    chk(chan_busy, 1'b0);
    // Progress flags and the channel request
    wr(IA, 32'h0000_0000);
    src_pointer <= 16'h0008;
    pulse(3, 8'h00);
    src_pointer <= 16'h0010;
    pulse(3, 8'h00);
    for (int k = 4; k < 8; k++) begin
      pulse(k, 8'h00);
    end
    rd(IA, 32'h0000_00f9);
    wr(IA, 32'h0080_00f9);
    idle(2);
    chk(chan_irq, 1'b1);
    wr(IA, 32'h0080_0079);
    idle(2);
    chk(chan_irq, 1'b0);
    conclude();
  end
endmodule : tb_dcc_channel
